// ---- cbal_pkg.sv ----
// Package of the cell-balancing switch and timer register bank.
// Assumes a single 200 MHz core clock and an AHB-Lite register bus.
package cbal_pkg;

   // ----------------------------------------------------------------
   // Register indexes, byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_SW_CTRL   = 8'h6F;  // balance_switch_control
   localparam logic [7:0] IDX_EXP_MAST  = 8'h70;  // balance_expiry_master
   localparam logic [7:0] IDX_EXP_CELL2 = 8'h71;  // balance_expiry_cell_two
   localparam logic [7:0] IDX_EXP_CELL3 = 8'h72;  // balance_expiry_cell_three
   localparam logic [7:0] IDX_BAL_CTRL  = 8'h60;  // balancing_control_register
   localparam logic [7:0] IDX_STATUS    = 8'h61;  // timer and state readback

   // ----------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------
   localparam int         NUM_CELLS     = 14;
   localparam int         EXP_W         = 10;
   localparam int         RESTART_BIT   = 15;
   localparam int         UNIT_LSB      = 4;
   localparam int         STAT_RUN_BIT  = 12;
   localparam int         STAT_DONE_BIT = 13;
   localparam logic [9:0] EXP_FOREVER   = 10'h3FF;
   localparam logic [9:0] EXP_RESET     = 10'h000;
   localparam logic [9:0] TIMER_MAX     = 10'h3FE;
   localparam logic [13:0] SW_RESET     = 14'h0000;
   localparam logic [2:0] MODE_OFF      = 3'h0;
   localparam logic [2:0] MODE_MANUAL   = 3'h1;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;

   // ----------------------------------------------------------------
   // Timebase
   // ----------------------------------------------------------------
   localparam int         SEC_NS        = 1_000_000_000;
   localparam int         CLK_PERIOD_NS = 5;
   localparam int         CYC_PER_SEC   = SEC_NS / CLK_PERIOD_NS;
   localparam int         PRESC_W       = 28;
   localparam logic [1:0] UNIT_SEC      = 2'h0;
   localparam logic [1:0] UNIT_MIN      = 2'h1;
   localparam logic [1:0] UNIT_HOUR     = 2'h2;
   localparam logic [11:0] SECS_PER_MIN  = 12'h03C;
   localparam logic [11:0] SECS_PER_HOUR = 12'hE10;

   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_RUN  = 2'b01,
      S_DONE = 2'b11
   } cbal_state_t;

   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [31:0] hwdata;
   } cbal_ahb_req_t;

   typedef struct packed {
      logic        hreadyout;
      logic        hresp;
      logic [31:0] hrdata;
   } cbal_ahb_rsp_t;

   typedef struct packed {
      cbal_state_t        st;
      logic [2:0]         mode;
      logic [1:0]         unit;
      logic [13:0]        sw_en;
      logic [9:0]         exp_m;
      logic [9:0]         exp2;
      logic [9:0]         exp3;
      logic [9:0]         timer;
      logic [PRESC_W-1:0] presc;
      logic [11:0]        secs;
      logic               dp_wr;
      logic [7:0]         dp_idx;
      logic [13:0]        sw_out;
      logic [31:0]        hrdata;
   } cbal_regs_t;

endpackage : cbal_pkg

// ---- cbal_switch_timer.sv ----
// Cell-balancing switch control, expiration registers and balancing timer.
// Assumes one AHB-Lite master on core_clk and switch drivers outside.
//
// Overview of operation
// - Writes to the switch-enable bits are ignored while the mode is 001 or any 1xx code.
// - Writing one to the restart bit clears the timer, writing zero leaves it running.
// - The restart bit is a self-clearing strobe and always reads back as zero.
// - The restart strobe only acts in manual balancing mode.
// - After the timer has expired a restart write has no effect.
// - Switch-enable bit n closes the balancing switch across cell n+1.
// - Master expiration writes are blocked whenever the mode is not 000.
// - The master expiration serves group, discharge and manual watchdog modes.
// - The per-cell expirations for cells two and three are used only in individual modes.
// - Per-cell expiration writes are blocked while the mode is any 1xx code.
// - Each expiration is ten bits whose unit is the hour, minute or second selected.
// - An expiration of 0x3FF never expires.
// - An expiration of 0x000 counts as already expired and disables balancing.
`timescale 1ns/1ps
`default_nettype none

module cbal_switch_timer
   import cbal_pkg::*;
#(
   parameter int CYC_SEC = CYC_PER_SEC
) (
   // Clock and reset
   input  wire logic          core_clk,
   input  wire logic          nrst,
   // Register bus
   input  wire cbal_pkg::cbal_ahb_req_t ahb_i,
   input  wire logic          hready,
   output var  cbal_pkg::cbal_ahb_rsp_t ahb_o,
   // Switch drivers
   output logic [13:0]        balance_switch_on
);
   import cbal_pkg::*;

   cbal_regs_t  s_q;
   cbal_regs_t  s_d;
   logic        wr_sw;
   logic        wr_mast;
   logic        wr_cell;
   logic        wr_ctrl;
   logic        restart_ok;
   logic        unit_tick;
   logic        done;
   logic [13:0] alive;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // A cell is expired when its setting is zero or the timer reached it.
   function automatic logic cell_expired(logic [9:0] e, logic [9:0] t);
      return (e == EXP_RESET) || ((e != EXP_FOREVER) && (t >= e));
   endfunction : cell_expired

   // Individual modes carry their own per-cell settings where present.
   function automatic logic [9:0] cell_exp(int n, cbal_regs_t s);
      logic [9:0] e;
      e = s.exp_m;
      if (s.mode[2] && n == 1) begin
         e = s.exp2;
      end else if (s.mode[2] && n == 2) begin
         e = s.exp3;
      end
      return e;
   endfunction : cell_exp

   // Seconds per timer LSB for the selected unit.
   function automatic logic [11:0] unit_secs(logic [1:0] u);
      logic [11:0] r;
      case (u)
         UNIT_MIN:  r = SECS_PER_MIN;
         UNIT_HOUR: r = SECS_PER_HOUR;
         default:   r = 12'h001;
      endcase
      return r;
   endfunction : unit_secs

   // Read mux, the restart strobe never reads back as one.
   function automatic logic [31:0] rd_mux(logic [7:0] idx, cbal_regs_t s);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (idx)
         IDX_SW_CTRL:   r[13:0] = s.sw_en;
         IDX_EXP_MAST:  r[9:0]  = s.exp_m;
         IDX_EXP_CELL2: r[9:0]  = s.exp2;
         IDX_EXP_CELL3: r[9:0]  = s.exp3;
         IDX_BAL_CTRL:  r[5:0]  = {s.unit, 1'b0, s.mode};
         IDX_STATUS: begin
            r[9:0]          = s.timer;
            r[STAT_RUN_BIT]  = (s.st == S_RUN);
            r[STAT_DONE_BIT] = (s.st == S_DONE);
         end
         default:       r = 32'h0000_0000;
      endcase
      return r;
   endfunction : rd_mux

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------

   // Bus decode, timebase, timer state and switch drive in one place.
   always_comb begin
      s_d       = s_q;
      s_d.dp_wr = 1'b0;
      wr_sw     = s_q.dp_wr && (s_q.dp_idx == IDX_SW_CTRL);
      wr_mast   = s_q.dp_wr && (s_q.dp_idx == IDX_EXP_MAST);
      wr_cell   = s_q.dp_wr && ((s_q.dp_idx == IDX_EXP_CELL2) || (s_q.dp_idx == IDX_EXP_CELL3));
      wr_ctrl   = s_q.dp_wr && (s_q.dp_idx == IDX_BAL_CTRL);
      restart_ok = wr_sw && ahb_i.hwdata[RESTART_BIT] && (s_q.mode == MODE_MANUAL)
                   && (s_q.st == S_RUN);

      // switch word locked in manual and automated modes.
      if (wr_sw && (s_q.mode != MODE_MANUAL) && !s_q.mode[2]) begin
         s_d.sw_en = ahb_i.hwdata[13:0];
      end
      // master setting writable only with balancing off.
      if (wr_mast && (s_q.mode == MODE_OFF)) begin
         s_d.exp_m = ahb_i.hwdata[9:0];
      end
      // per-cell settings locked in automated modes.
      if (wr_cell && !s_q.mode[2]) begin
         if (s_q.dp_idx == IDX_EXP_CELL2) begin
            s_d.exp2 = ahb_i.hwdata[9:0];
         end else begin
            s_d.exp3 = ahb_i.hwdata[9:0];
         end
      end

      // seconds prescaler and unit divider set the timer LSB.
      unit_tick = 1'b0;
      if (s_q.st == S_RUN) begin
         if (s_q.presc == PRESC_W'(CYC_SEC - 1)) begin
            s_d.presc = '0;
            if (s_q.secs == unit_secs(s_q.unit) - 12'h001) begin
               s_d.secs  = 12'h000;
               unit_tick = 1'b1;
            end else begin
               s_d.secs = s_q.secs + 12'h001;
            end
         end else begin
            s_d.presc = s_q.presc + PRESC_W'(1);
         end
      end

      for (int n = 0; n < NUM_CELLS; n++) begin
         alive[n] = !cell_expired(cell_exp(n, s_q), s_q.timer);
      end
      done = s_q.mode[2] ? ((s_q.sw_en & alive) == 14'h0000) : !alive[0];

      // run until expiry, then hold the timer stopped.
      case (s_q.st)
         S_IDLE: begin
            s_d.st = S_IDLE;
         end
         S_RUN: begin
            if (done) begin
               s_d.st = S_DONE;
            end else if (unit_tick && s_q.timer != TIMER_MAX) begin
               s_d.timer = s_q.timer + 10'h001;
            end
         end
         S_DONE: begin
            s_d.st = S_DONE;
         end
         default: begin
            s_d.st = S_IDLE;
         end
      endcase

      // restart clears the timer and the divider with it.
      if (restart_ok && !done) begin
         s_d.timer = 10'h000;
         s_d.presc = '0;
         s_d.secs  = 12'h000;
      end

      // a control write starts a fresh event or stops balancing.
      if (wr_ctrl) begin
         s_d.mode  = ahb_i.hwdata[2:0];
         s_d.unit  = ahb_i.hwdata[UNIT_LSB +: 2];
         s_d.timer = 10'h000;
         s_d.presc = '0;
         s_d.secs  = 12'h000;
         s_d.st    = (ahb_i.hwdata[2:0] == MODE_OFF) ? S_IDLE : S_RUN;
      end

      // enabled, unexpired cells conduct while an event runs.
      s_d.sw_out = (s_q.st == S_RUN && !done) ? (s_q.sw_en & alive) : SW_RESET;

      // Address phase capture; zero wait states, so hready is always ours.
      if (ahb_i.hsel && ahb_i.htrans[1] && hready) begin
         s_d.dp_idx = (ahb_i.haddr[31:10] == 22'h000000) ? ahb_i.haddr[9:2] : 8'hFF;
         s_d.dp_wr  = ahb_i.hwrite && (ahb_i.hsize == HSIZE_WORD);
         // readback sees the write of the data phase just ending.
         s_d.hrdata = ahb_i.hwrite ? 32'h0000_0000 : rd_mux(s_d.dp_idx, s_d);
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------

   // Everything resets to constants; expirations reset as already expired.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s_q        <= '0;
         s_q.st     <= S_IDLE;
         s_q.mode   <= MODE_OFF;
         s_q.sw_en  <= SW_RESET;
         s_q.exp_m  <= EXP_RESET;
         s_q.exp2   <= EXP_RESET;
         s_q.exp3   <= EXP_RESET;
         s_q.sw_out <= SW_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // Read data and switch drive straight from flops; ready and response tied off, so the slave never stalls or errors.
   assign ahb_o.hreadyout = 1'b1;
   assign ahb_o.hresp     = 1'b0;
   assign ahb_o.hrdata    = s_q.hrdata;
   assign balance_switch_on = s_q.sw_out;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   a_sw_lock_mode: assert property (
      wr_sw && (s_q.mode == MODE_MANUAL || s_q.mode[2]) |=> $stable(s_q.sw_en))
      else $error("switch word changed while locked");

   a_restart_clear: assert property (
      restart_ok && !done && !wr_ctrl |=> s_q.timer == 10'h000 && s_q.st == S_RUN)
      else $error("restart did not clear the timer");

   a_restart_reads_zero: assert property (
      ahb_i.hsel && ahb_i.htrans[1] && !ahb_i.hwrite && ahb_i.haddr[9:2] == IDX_SW_CTRL
      |=> ahb_o.hrdata[RESTART_BIT] == 1'b0)
      else $error("restart bit read back as one");

   a_restart_manual_only: assert property (
      wr_sw && ahb_i.hwdata[RESTART_BIT] && s_q.mode != MODE_MANUAL && !wr_ctrl
      && s_q.timer != 10'h000 |=> s_q.timer != 10'h000)
      else $error("restart acted outside manual mode");

   a_restart_expired: assert property (
      s_q.st == S_DONE && wr_sw && !wr_ctrl |=> s_q.st == S_DONE ##1 s_q.sw_out == SW_RESET)
      else $error("restart revived an expired event");

   a_sw_follow: assert property (
      s_q.st == S_RUN && s_q.mode == MODE_MANUAL && s_q.exp_m == EXP_FOREVER
      |=> balance_switch_on == $past(s_q.sw_en))
      else $error("switch drive does not follow enables");

   a_master_lock: assert property (
      wr_mast && s_q.mode != MODE_OFF |=> $stable(s_q.exp_m))
      else $error("master expiry written while balancing");

   a_cell_lock: assert property (
      wr_cell && s_q.mode[2] |=> $stable(s_q.exp2) && $stable(s_q.exp3))
      else $error("cell expiry written in automated mode");

   a_never_expire: assert property (
      s_q.st == S_RUN && !s_q.mode[2] && s_q.exp_m == EXP_FOREVER && !wr_ctrl
      |=> s_q.st == S_RUN)
      else $error("indefinite setting expired");

   a_zero_expired: assert property (
      s_q.st == S_RUN && !s_q.mode[2] && s_q.exp_m == EXP_RESET && !wr_ctrl
      |=> s_q.st == S_DONE ##1 balance_switch_on == SW_RESET)
      else $error("zero setting did not expire at once");

   a_expiry_opens: assert property (
      s_q.st == S_DONE && !wr_ctrl |=> balance_switch_on == SW_RESET && $stable(s_q.timer))
      else $error("switches left closed after expiry");

   c_manual_expiry:  cover property (s_q.mode == MODE_MANUAL && s_q.st == S_RUN ##1 s_q.st == S_DONE);
   c_restart_taken:  cover property (restart_ok && !done);
   c_individual_run: cover property (s_q.mode[2] && s_q.st == S_RUN && balance_switch_on != SW_RESET);
   c_timer_counts:   cover property (unit_tick && s_q.st == S_RUN);

endmodule : cbal_switch_timer

`default_nettype wire

// ---- cbal_tb.sv ----
// Self-checking testbench of the cell-balancing switch and timer bank.
// Assumes the package cbal_pkg and one AHB-Lite master with no wait states.
`timescale 1ns/1ps
`default_nettype none

module tb;
   import cbal_pkg::*;

   // Cycles per second, shortened so that timer events take a few cycles.
   localparam int CS = 4;

   typedef struct packed {
      logic [7:0]  idx;
      logic [31:0] wd;
      logic [31:0] ex;
   } cbal_row_t;

   logic          core_clk    = 1'b0;
   logic          nrst        = 1'b0;
   cbal_ahb_req_t req         = '0;
   cbal_ahb_rsp_t rsp;
   logic [13:0]   sw_on;
   logic [31:0]   rd;
   int            miscompares = 0;
   int            tests_run   = 0;
   cbal_row_t     rows [7];

   cbal_switch_timer #(.CYC_SEC(CS)) cbal_switch_timer_inst (
      .core_clk          (core_clk),
      .nrst              (nrst),
      .ahb_i             (req),
      .hready            (rsp.hreadyout),
      .ahb_o             (rsp),
      .balance_switch_on (sw_on)
   );

   // Free-running 200 MHz clock.
   always #2.5 core_clk = ~core_clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] ex);
      tests_run++;
      if (got !== ex) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, ex);
      end
   endtask : chk

   // One single transfer; entered just after a rising edge, leaves just after one.
   task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      req <= '{1'b1, {22'h0, idx, 2'b00}, 2'b10, w, HSIZE_WORD, req.hwdata};
      do @(posedge core_clk); while (rsp.hreadyout !== 1'b1);
      req <= '{1'b0, req.haddr, 2'b00, w, HSIZE_WORD, wd};
      do @(posedge core_clk); while (rsp.hreadyout !== 1'b1);
      rd = rsp.hrdata;
   endtask : bus

   task automatic rdc(input logic [7:0] idx, input logic [31:0] ex);
      bus(1'b0, idx, 32'h0);
      chk(rd, ex);
   endtask : rdc

   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
   endtask : wt

   task automatic close_out();
      $display("Counts: %0d comparisons, %0d mismatches", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : close_out

   // Watchdog; the whole sequence needs well under 10000 cycles.
   initial begin
      #100us;
      miscompares++;
      close_out();
   end

   // Main sequence: register table first, then reset and timer cases.
   initial begin
      rows[0] = '{IDX_SW_CTRL, 32'h0000_3FFF, 32'h0000_3FFF};
      rows[1] = '{IDX_SW_CTRL, 32'hFFFF_FFFF, 32'h0000_3FFF};
      rows[2] = '{IDX_EXP_MAST, 32'h0000_03FF, 32'h0000_03FF};
      rows[3] = '{IDX_EXP_MAST, 32'hFFFF_FC00, 32'h0000_0000};
      rows[4] = '{IDX_EXP_CELL2, 32'h0000_0155, 32'h0000_0155};
      rows[5] = '{IDX_EXP_CELL3, 32'h0000_02AA, 32'h0000_02AA};
      rows[6] = '{8'h50, 32'hFFFF_FFFF, 32'h0000_0000};
      wt(10);
      nrst <= 1'b1;
      wt(1);
      foreach (rows[i]) begin
         bus(1'b1, rows[i].idx, rows[i].wd);
         rdc(rows[i].idx, rows[i].ex);
         chk(32'(sw_on), 32'h0);
      end
      $display("Test done: register table");
      // A second reset in mid-run brings every register back to zero.
      nrst <= 1'b0;
      wt(2);
      chk(32'(sw_on), 32'h0);
      nrst <= 1'b1;
      wt(1);
      rdc(IDX_SW_CTRL, 32'h0);
      rdc(IDX_EXP_MAST, 32'h0);
      rdc(IDX_EXP_CELL2, 32'h0);
      rdc(IDX_EXP_CELL3, 32'h0);
      rdc(IDX_STATUS, 32'h0);
      $display("Test done: reset values");
      // Write locks for every nonzero mode code.
      for (int m = 1; m < 8; m++) begin
         bus(1'b1, IDX_BAL_CTRL, 32'h0);
         bus(1'b1, IDX_SW_CTRL, 32'h11);
         bus(1'b1, IDX_EXP_MAST, 32'h11);
         bus(1'b1, IDX_EXP_CELL2, 32'h11);
         bus(1'b1, IDX_BAL_CTRL, 32'(m));
         bus(1'b1, IDX_SW_CTRL, 32'h22);
         bus(1'b1, IDX_EXP_MAST, 32'h22);
         bus(1'b1, IDX_EXP_CELL2, 32'h22);
         rdc(IDX_SW_CTRL, (m == 2 || m == 3) ? 32'h22 : 32'h11);
         rdc(IDX_EXP_MAST, 32'h11);
         rdc(IDX_EXP_CELL2, m[2] ? 32'h11 : 32'h22);
      end
      $display("Test done: write locks");
      // Manual mode with a five second watchdog and restarts.
      bus(1'b1, IDX_BAL_CTRL, 32'h0);
      bus(1'b1, IDX_SW_CTRL, 32'h5);
      bus(1'b1, IDX_EXP_MAST, 32'h5);
      bus(1'b1, IDX_BAL_CTRL, 32'h1);
      wt(4);
      chk(32'(sw_on), 32'h5);
      wt(6);
      bus(1'b1, IDX_SW_CTRL, 32'h0);
      rdc(IDX_SW_CTRL, 32'h5);
      bus(1'b0, IDX_STATUS, 32'h0);
      chk(rd & 32'h3FFF, 32'h1003);
      bus(1'b1, IDX_SW_CTRL, 32'h8000);
      bus(1'b0, IDX_STATUS, 32'h0);
      chk(rd & 32'h3FFF, 32'h1000);
      wt(30);
      bus(1'b0, IDX_STATUS, 32'h0);
      chk(rd & 32'h3000, 32'h2000);
      chk(32'(sw_on), 32'h0);
      bus(1'b1, IDX_SW_CTRL, 32'h8000);
      wt(8);
      chk(32'(sw_on), 32'h0);
      bus(1'b1, IDX_BAL_CTRL, 32'h1);
      wt(4);
      chk(32'(sw_on), 32'h5);
      $display("Test done: manual watchdog");
      // Group mode: restart ignored, master expiry closes the event.
      bus(1'b1, IDX_BAL_CTRL, 32'h0);
      wt(2);
      chk(32'(sw_on), 32'h0);
      bus(1'b1, IDX_BAL_CTRL, 32'h2);
      bus(1'b1, IDX_SW_CTRL, 32'h3);
      wt(8);
      chk(32'(sw_on), 32'h3);
      bus(1'b1, IDX_SW_CTRL, 32'h8003);
      bus(1'b0, IDX_STATUS, 32'h0);
      chk(32'(rd[9:0] == 10'h0), 32'h0);
      wt(30);
      chk(32'(sw_on), 32'h0);
      // Zero expiry ends a discharge event at once.
      bus(1'b1, IDX_BAL_CTRL, 32'h0);
      bus(1'b1, IDX_EXP_MAST, 32'h0);
      bus(1'b1, IDX_BAL_CTRL, 32'h3);
      wt(3);
      chk(32'(sw_on), 32'h0);
      rdc(IDX_STATUS, 32'h2000);
      // All-ones expiry runs on past the saturated timer.
      bus(1'b1, IDX_BAL_CTRL, 32'h0);
      bus(1'b1, IDX_EXP_MAST, 32'h3FF);
      bus(1'b1, IDX_BAL_CTRL, 32'h1);
      wt(4200);
      chk(32'(sw_on), 32'h3);
      bus(1'b0, IDX_STATUS, 32'h0);
      chk(rd & 32'h3000, 32'h1000);
      $display("Test done: expiry limits");
      // Minute unit: one tick needs sixty seconds.
      bus(1'b1, IDX_BAL_CTRL, 32'h0);
      bus(1'b1, IDX_EXP_MAST, 32'h1);
      bus(1'b1, IDX_BAL_CTRL, 32'h11);
      wt(200);
      chk(32'(sw_on), 32'h3);
      wt(80);
      chk(32'(sw_on), 32'h0);
      // Individual mode: cells two and three use their own settings.
      bus(1'b1, IDX_BAL_CTRL, 32'h0);
      bus(1'b1, IDX_EXP_MAST, 32'h3FF);
      bus(1'b1, IDX_EXP_CELL2, 32'h2);
      bus(1'b1, IDX_EXP_CELL3, 32'h6);
      bus(1'b1, IDX_SW_CTRL, 32'h6);
      bus(1'b1, IDX_BAL_CTRL, 32'h4);
      wt(14);
      chk(32'(sw_on), 32'h4);
      wt(20);
      chk(32'(sw_on), 32'h0);
      rdc(IDX_STATUS, 32'h2006);
      $display("Test done: timer modes");
      close_out();
   end

endmodule : tb

`default_nettype wire
